// ===== logic/lane_cfg_pkg.sv
package lane_cfg_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] ADDR_B0_DEEMPHASIS = 8'h11;
    localparam logic [7:0] ADDR_B0_THRESHOLD = 8'h12;
    localparam logic [7:0] ADDR_RESERVED_A = 8'h13;
    localparam logic [7:0] ADDR_RESERVED_B = 8'h14;
    localparam logic [7:0] ADDR_B1_PROBE = 8'h15;
    localparam logic [7:0] ADDR_B1_BOOST = 8'h16;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int TERM_STATUS_BIT = 7;
    localparam int DEEMPH_MSB = 2;
    localparam int DEEMPH_LSB = 0;
    localparam int ASSERT_MSB = 3;
    localparam int ASSERT_LSB = 2;
    localparam int DEASSERT_MSB = 1;
    localparam int DEASSERT_LSB = 0;
    localparam int PROBE_MSB = 3;
    localparam int PROBE_LSB = 2;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [2:0] RST_DEEMPHASIS = 3'h2;
    localparam logic [1:0] RST_ASSERT = 2'h0;
    localparam logic [1:0] RST_DEASSERT = 2'h0;
    localparam logic [7:0] RST_RESERVED = 8'h00;
    localparam logic [1:0] RST_PROBE = 2'h0;
    localparam logic [7:0] RST_BOOST = 8'h2F;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // ************************************************************
    // Receiver probe modes
    // ************************************************************
    localparam logic [1:0] PROBE_HIZ = 2'h0;
    localparam logic [1:0] PROBE_LIMITED = 2'h1;
    localparam logic [1:0] PROBE_ENDLESS = 2'h2;
    localparam logic [1:0] PROBE_FIXED = 2'h3;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_HZ = 20000000;
    localparam int PROBE_INTERVAL_MS = 12;
    localparam int PROBE_WINDOW_MS = 600;
    localparam int PROBE_INTERVAL_CYC = PROBE_INTERVAL_MS * (CLK_HZ / 1000);
    localparam int PROBE_ATTEMPTS = PROBE_WINDOW_MS / PROBE_INTERVAL_MS;
    localparam int PROBE_CNT_W = 18;
    localparam int PROBE_TRY_W = 6;
    localparam int SYNC_W = 8;

    // ************************************************************
    // Register access carrier
    // ************************************************************
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_req_type;

endpackage

// ===== logic/receiver_probe_seq.sv
`timescale 1ns/1ps
`default_nettype none
module receiver_probe_seq
    import lane_cfg_pkg::*;
#(
    parameter int unsigned INTERVAL_CYC = PROBE_INTERVAL_CYC
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [1:0] mode,
    input wire logic receiver_seen,
    output logic probe_pulse,
    output logic term_on
);

    typedef enum logic [2:0] {
        seq_hiz,
        seq_wait,
        seq_check,
        seq_stopped,
        seq_linked,
        seq_fixed
    } seq_state_type;

    localparam logic [PROBE_CNT_W-1:0] LAST_CNT = PROBE_CNT_W'(INTERVAL_CYC - 1);
    localparam logic [PROBE_TRY_W-1:0] LAST_TRY = PROBE_TRY_W'(PROBE_ATTEMPTS);

    seq_state_type state_r;
    logic [1:0] mode_r;
    logic [PROBE_CNT_W-1:0] cnt_r;
    logic [PROBE_TRY_W-1:0] tries_r;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_r <= seq_hiz;
            mode_r <= PROBE_HIZ;
            cnt_r <= '0;
            tries_r <= '0;
            probe_pulse <= 1'b0;
            term_on <= 1'b0;
        end else begin
            mode_r <= mode;
            probe_pulse <= 1'b0;
            if (mode != mode_r) begin
                cnt_r <= '0;
                tries_r <= '0;
                term_on <= (mode == PROBE_FIXED);
                case (mode)
                    PROBE_HIZ: state_r <= seq_hiz;
                    PROBE_FIXED: state_r <= seq_fixed;
                    default: state_r <= seq_wait;
                endcase
            end else begin
                case (state_r)
                    seq_wait: begin
                        if (cnt_r == LAST_CNT) begin
                            cnt_r <= '0;
                            probe_pulse <= 1'b1;
                            tries_r <= tries_r + 1'b1;
                            state_r <= seq_check;
                        end else begin
                            cnt_r <= cnt_r + 1'b1;
                        end
                    end
                    seq_check: begin
                        if (receiver_seen) begin
                            state_r <= seq_linked;
                            term_on <= 1'b1;
                        end else if (mode == PROBE_LIMITED && tries_r == LAST_TRY) begin
                            state_r <= seq_stopped;
                        end else begin
                            cnt_r <= cnt_r + 1'b1;
                            state_r <= seq_wait;
                        end
                    end
                    seq_hiz, seq_stopped: term_on <= 1'b0;
                    seq_linked, seq_fixed: term_on <= 1'b1;
                    default: state_r <= seq_hiz;
                endcase
            end
        end
    end

endmodule
`default_nettype wire

// ===== logic/lane_config_registers.sv
`timescale 1ns/1ps
`default_nettype none
module lane_config_registers
    import lane_cfg_pkg::*;
#(
    parameter int unsigned PROBE_INTERVAL = PROBE_INTERVAL_CYC
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire reg_req_type reg_req,
    output logic [7:0] rd_data,
    output logic rd_valid,
    input wire logic override_threshold,
    input wire logic override_probe,
    input wire logic pin_lane0_terminated,
    input wire logic pin_receiver_seen,
    input wire logic [3:0] pin_threshold,
    input wire logic [1:0] pin_probe_mode,
    output logic [2:0] output_deemphasis,
    output logic [1:0] signal_detect_assert,
    output logic [1:0] signal_detect_deassert,
    output logic [7:0] input_boost_level,
    output logic probe_pulse,
    output logic port_b_in_lane1_term
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [SYNC_W-1:0] sync_a_r;
    logic [SYNC_W-1:0] sync_b_r;
    logic lane0_terminated;
    logic receiver_seen;
    logic [3:0] threshold_pin;
    logic [1:0] probe_pin;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sync_a_r <= '0;
            sync_b_r <= '0;
        end else begin
            sync_a_r <= {pin_lane0_terminated, pin_receiver_seen, pin_threshold, pin_probe_mode};
            sync_b_r <= sync_a_r;
        end
    end

    assign lane0_terminated = sync_b_r[7];
    assign receiver_seen = sync_b_r[6];
    assign threshold_pin = sync_b_r[5:2];
    assign probe_pin = sync_b_r[1:0];

    // ************************************************************
    // Register storage
    // ************************************************************
    logic [2:0] deemph_r;
    logic [1:0] assert_r;
    logic [1:0] deassert_r;
    logic [7:0] reserved_a_r;
    logic [7:0] reserved_b_r;
    logic [1:0] probe_mode_r;
    logic [7:0] boost_r;
    logic wr_deemph;
    logic wr_threshold;
    logic wr_reserved_a;
    logic wr_reserved_b;
    logic wr_probe;
    logic wr_boost;

    // Unmapped offsets raise no strobe, so those writes vanish
    assign wr_deemph = reg_req.wr && (reg_req.addr == ADDR_B0_DEEMPHASIS);
    assign wr_threshold = reg_req.wr && (reg_req.addr == ADDR_B0_THRESHOLD);
    assign wr_reserved_a = reg_req.wr && (reg_req.addr == ADDR_RESERVED_A);
    assign wr_reserved_b = reg_req.wr && (reg_req.addr == ADDR_RESERVED_B);
    assign wr_probe = reg_req.wr && (reg_req.addr == ADDR_B1_PROBE);
    assign wr_boost = reg_req.wr && (reg_req.addr == ADDR_B1_BOOST);

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            deemph_r <= RST_DEEMPHASIS;
        end else if (wr_deemph) begin
            deemph_r <= reg_req.data[DEEMPH_MSB:DEEMPH_LSB];
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            assert_r <= RST_ASSERT;
            deassert_r <= RST_DEASSERT;
        end else if (wr_threshold) begin
            assert_r <= reg_req.data[ASSERT_MSB:ASSERT_LSB];
            deassert_r <= reg_req.data[DEASSERT_MSB:DEASSERT_LSB];
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            reserved_a_r <= RST_RESERVED;
        end else if (wr_reserved_a) begin
            reserved_a_r <= reg_req.data;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            reserved_b_r <= RST_RESERVED;
        end else if (wr_reserved_b) begin
            reserved_b_r <= reg_req.data;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            probe_mode_r <= RST_PROBE;
        end else if (wr_probe) begin
            probe_mode_r <= reg_req.data[PROBE_MSB:PROBE_LSB];
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            boost_r <= RST_BOOST;
        end else if (wr_boost) begin
            boost_r <= reg_req.data;
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    logic [7:0] rd_nxt;

    always_comb begin
        rd_nxt = READ_UNMAPPED;
        case (reg_req.addr)
            ADDR_B0_DEEMPHASIS: begin
                rd_nxt[DEEMPH_MSB:DEEMPH_LSB] = deemph_r;
                rd_nxt[TERM_STATUS_BIT] = lane0_terminated;
            end
            ADDR_B0_THRESHOLD: begin
                rd_nxt[ASSERT_MSB:ASSERT_LSB] = assert_r;
                rd_nxt[DEASSERT_MSB:DEASSERT_LSB] = deassert_r;
            end
            ADDR_RESERVED_A: rd_nxt = reserved_a_r;
            ADDR_RESERVED_B: rd_nxt = reserved_b_r;
            ADDR_B1_PROBE: rd_nxt[PROBE_MSB:PROBE_LSB] = probe_mode_r;
            ADDR_B1_BOOST: rd_nxt = boost_r;
            default: rd_nxt = READ_UNMAPPED;
        endcase
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= reg_req.rd;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rd_data <= READ_UNMAPPED;
        end else if (reg_req.rd) begin
            rd_data <= rd_nxt;
        end
    end

    // ************************************************************
    // Analog control outputs
    // ************************************************************
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            output_deemphasis <= RST_DEEMPHASIS;
        end else begin
            output_deemphasis <= deemph_r;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            input_boost_level <= RST_BOOST;
        end else begin
            input_boost_level <= boost_r;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            signal_detect_assert <= RST_ASSERT;
            signal_detect_deassert <= RST_DEASSERT;
        end else if (override_threshold) begin
            signal_detect_assert <= assert_r;
            signal_detect_deassert <= deassert_r;
        end else begin
            signal_detect_assert <= threshold_pin[3:2];
            signal_detect_deassert <= threshold_pin[1:0];
        end
    end

    // ************************************************************
    // Lane 1 receiver probe
    // ************************************************************
    logic [1:0] probe_mode_eff;

    assign probe_mode_eff = override_probe ? probe_mode_r : probe_pin;

    receiver_probe_seq #(
        .INTERVAL_CYC(PROBE_INTERVAL)
    ) i_receiver_probe_seq (
        .core_clk(core_clk),
        .reset(reset),
        .mode(probe_mode_eff),
        .receiver_seen(receiver_seen),
        .probe_pulse(probe_pulse),
        .term_on(port_b_in_lane1_term)
    );

endmodule
`default_nettype wire

// ===== bench/far_end_receiver.sv
`timescale 1ns/1ps
`default_nettype none
module far_end_receiver (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic probe_pulse,
    input wire logic arm,
    input wire logic [7:0] detect_after,
    output logic present
);
    logic [7:0] seen_r;
    // ************************************************************
    // Shows up only after the commanded number of probes
    // ************************************************************
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            seen_r <= 8'h00;
        end else if (!arm) begin
            seen_r <= 8'h00;
        end else if (probe_pulse) begin
            seen_r <= seen_r + 8'h01;
        end
    end
    assign present = arm && (seen_r >= detect_after);
endmodule
`default_nettype wire

// ===== bench/lane_cfg_props.sv
`timescale 1ns/1ps
`default_nettype none
module lane_cfg_props
    import lane_cfg_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire reg_req_type reg_req,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    input wire logic override_threshold,
    input wire logic override_probe,
    input wire logic [3:0] pin_threshold,
    input wire logic [1:0] pin_probe_mode,
    input wire logic [2:0] output_deemphasis,
    input wire logic [1:0] signal_detect_assert,
    input wire logic [7:0] input_boost_level,
    input wire logic probe_pulse,
    input wire logic port_b_in_lane1_term
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    a_read_answer: assert property (reg_req.rd |=> rd_valid)
        else $error("read answer missing");
    a_no_read_valid: assert property (!reg_req.rd |=> !rd_valid)
        else $error("read answer without read");
    a_boost_readback: assert property (reg_req.rd && reg_req.addr == ADDR_B1_BOOST |=> rd_data == input_boost_level)
        else $error("boost read differs from output");
    a_boost_write: assert property (reg_req.wr && reg_req.addr == ADDR_B1_BOOST |=> ##1
        input_boost_level == $past(reg_req.data, 2)) else $error("boost output not written");
    a_deemph_readback: assert property (reg_req.rd && reg_req.addr == ADDR_B0_DEEMPHASIS |=>
        rd_data[2:0] == output_deemphasis) else $error("deemphasis read differs from output");
    a_unmapped_zero: assert property (reg_req.rd &&
        (reg_req.addr < ADDR_B0_DEEMPHASIS || reg_req.addr > ADDR_B1_BOOST)
        |=> rd_data == READ_UNMAPPED) else $error("unmapped read not zero");
    a_pulse_gap: assert property (probe_pulse |=> (!probe_pulse) [*8])
        else $error("probe pulses too close");
    a_thr_pin: assert property ((!override_threshold && $stable(pin_threshold)) [*5] |->
        signal_detect_assert == pin_threshold[3:2]) else $error("threshold pin not followed");
    a_probe_fixed: assert property (
        (!override_probe && $stable(pin_probe_mode) && pin_probe_mode == PROBE_FIXED) [*6]
        |-> port_b_in_lane1_term) else $error("fixed termination missing");
    a_probe_hiz: assert property (
        (!override_probe && $stable(pin_probe_mode) && pin_probe_mode == PROBE_HIZ) [*6]
        |-> !port_b_in_lane1_term && !probe_pulse) else $error("high impedance mode not kept");
endmodule
bind lane_config_registers lane_cfg_props i_lane_cfg_props (
    .core_clk, .reset, .reg_req, .rd_data, .rd_valid, .override_threshold, .override_probe, .pin_threshold,
    .pin_probe_mode, .output_deemphasis, .signal_detect_assert, .input_boost_level, .probe_pulse,
    .port_b_in_lane1_term
);
`default_nettype wire

// ===== bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import lane_cfg_pkg::*;
    logic core_clk = 1'b0, reset = 1'b1, override_threshold = 1'b0, override_probe = 1'b0;
    logic pin_lane0_terminated = 1'b0, pin_receiver_seen, rd_valid, probe_pulse, port_b_in_lane1_term, arm = 1'b0;
    logic [3:0] pin_threshold = 4'h6;
    logic [1:0] pin_probe_mode = 2'h0, signal_detect_assert, signal_detect_deassert;
    logic [2:0] output_deemphasis;
    logic [7:0] rd_data, input_boost_level, detect_after = 8'h00;
    logic [7:0] rst_tab [7] = '{8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h2F, 8'h00};
    reg_req_type reg_req = '0;
    int failures = 0, n_compared = 0, pulses = 0;
    lane_config_registers #(.PROBE_INTERVAL(20)) i_lane_config_registers (.core_clk, .reset, .reg_req, .rd_data,
        .rd_valid, .override_threshold, .override_probe, .pin_lane0_terminated, .pin_receiver_seen, .pin_threshold,
        .pin_probe_mode, .output_deemphasis, .signal_detect_assert, .signal_detect_deassert, .input_boost_level,
        .probe_pulse, .port_b_in_lane1_term);
    far_end_receiver i_far_end_receiver (.core_clk, .reset, .probe_pulse, .arm, .detect_after,
        .present(pin_receiver_seen));
    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) if (probe_pulse === 1'b1) pulses++;
    // ************************************************************
    // Access and compare tasks
    // ************************************************************
    task automatic stop_test;
        if (failures == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk) reg_req <= {1'b1, 1'b0, a, d};
        @(posedge core_clk) reg_req <= '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk) reg_req <= {1'b0, 1'b1, a, 8'h00};
        @(posedge core_clk) reg_req <= '0;
        #1;
        chk("rd_valid", 8'h01, {7'h00, rd_valid});
        chk("rd_data", exp, rd_data);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        stop_test;
    end
    initial begin
        int i;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        for (i = 0; i < 7; i++) rd(8'(ADDR_B0_DEEMPHASIS + i), rst_tab[i]);
        wr(8'h10, 8'hFF);
        rd(8'h10, 8'h00);
        for (i = 0; i < 8; i++) begin
            wr(ADDR_B0_DEEMPHASIS, 8'(i));
            rd(ADDR_B0_DEEMPHASIS, 8'(i));
            chk("output_deemphasis", 8'(i), {5'h00, output_deemphasis});
        end
        wr(ADDR_B0_DEEMPHASIS, 8'h00);
        pin_lane0_terminated <= 1'b1;
        settle(3);
        rd(ADDR_B0_DEEMPHASIS, 8'h80);
        wr(ADDR_RESERVED_A, 8'hA5);
        wr(ADDR_RESERVED_B, 8'h5A);
        rd(ADDR_RESERVED_A, 8'hA5);
        rd(ADDR_RESERVED_B, 8'h5A);
        wr(ADDR_B1_BOOST, 8'h05);
        rd(ADDR_B1_BOOST, 8'h05);
        chk("input_boost_level", 8'h05, input_boost_level);
        @(posedge core_clk) override_threshold <= 1'b1;
        for (i = 0; i < 4; i++) begin
            wr(ADDR_B0_THRESHOLD, 8'(i * 4 + 3 - i));
            rd(ADDR_B0_THRESHOLD, 8'(i * 4 + 3 - i));
            chk("signal_detect_assert", 8'(i), {6'h00, signal_detect_assert});
            chk("signal_detect_deassert", 8'(3 - i), {6'h00, signal_detect_deassert});
        end
        @(posedge core_clk) override_threshold <= 1'b0;
        settle(5);
        chk("signal_detect_deassert", 8'h02, {6'h00, signal_detect_deassert});
        @(posedge core_clk) pin_probe_mode <= PROBE_FIXED;
        settle(7);
        chk("port_b_in_lane1_term", 8'h01, {7'h00, port_b_in_lane1_term});
        @(posedge core_clk);
        pin_probe_mode <= PROBE_HIZ;
        override_probe <= 1'b1;
        wr(ADDR_B1_PROBE, 8'h0C);
        settle(3);
        chk("port_b_in_lane1_term", 8'h01, {7'h00, port_b_in_lane1_term});
        rd(ADDR_B1_PROBE, 8'h0C);
        wr(ADDR_B1_PROBE, 8'h00);
        settle(3);
        chk("port_b_in_lane1_term", 8'h00, {7'h00, port_b_in_lane1_term});
        pulses = 0;
        wr(ADDR_B1_PROBE, 8'h04);
        settle(1200);
        chk("probe count", 8'h32, 8'(pulses));
        chk("port_b_in_lane1_term", 8'h00, {7'h00, port_b_in_lane1_term});
        @(posedge core_clk);
        detect_after <= 8'h34;
        arm <= 1'b1;
        pulses = 0;
        wr(ADDR_B1_PROBE, 8'h08);
        for (i = 0; i < 1300 && port_b_in_lane1_term !== 1'b1; i++) @(posedge core_clk);
        #1;
        chk("port_b_in_lane1_term", 8'h01, {7'h00, port_b_in_lane1_term});
        chk("probe count", 8'h35, 8'(pulses));
        stop_test;
    end
endmodule
`default_nettype wire
